// ### design/emu_gate_pkg.sv
// Package of constants and carriers for the emulation run/break gating block
package emu_gate_pkg;
  // ---------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [23:0] TTE_RAM_LO = 24'hff_ebc0;
  localparam logic [23:0] TTE_RAM_HI = 24'hff_efbf;
  // Reset values of host mask bits: standby masked by default
  localparam logic MASK_INIT_RST = 1'b0;
  localparam logic MASK_NMI_RST = 1'b0;
  localparam logic MASK_STANDBY_INPUT_RST = 1'b1;
  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_EXP16 = 2'h0,
    MODE_EXP8 = 2'h1,
    MODE_EXPROM = 2'h2,
    MODE_SINGLE = 2'h3
  } op_mode_e;
  typedef enum logic [2:0] {
    TGT_NONE = 3'h0,
    TGT_SUB_ROM = 3'h1,
    TGT_SUB_RAM = 3'h2,
    TGT_IO = 3'h3,
    TGT_EMU_MEM = 3'h4,
    TGT_EXT = 3'h5
  } mem_tgt_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_BREAK = 2'b11
  } run_state_e;
  // Window of one area: base, last address, enable
  typedef struct packed {
    logic en;
    logic [23:0] lo;
    logic [23:0] hi;
  } area_s;
  // One memory request
  typedef struct packed {
    logic valid;
    logic wr;
    logic host;
    logic [23:0] addr;
  } mem_req_s;
  // Memory steering answer
  typedef struct packed {
    logic [2:0] tgt;
    logic grant;
    logic blocked;
    logic pin_wait_ok;
  } mem_ans_s;
endpackage : emu_gate_pkg

// ### design/emu_gate.sv
// Run/break gating, mode decode and memory steering of the emulator
//
// The implementer's own choices: the plain strobed port.
module emu_gate (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Mode pins from target
  input wire logic mode_select_pin_2_i,
  input wire logic mode_select_pin_1_i,
  input wire logic mode_select_pin_0_i,
  // Area map from host configuration
  input wire emu_gate_pkg::area_s rom_area_i,
  input wire emu_gate_pkg::area_s ram_area_i,
  input wire emu_gate_pkg::area_s io_area_i,
  input wire emu_gate_pkg::area_s emu_area_i,
  input wire emu_gate_pkg::area_s ext_area_i,
  input wire logic ext_rw_i,
  input wire logic ext_wprot_i,
  // Memory request
  input wire emu_gate_pkg::mem_req_s req_i,
  input wire logic tte_hi_xfer_i,
  input wire logic refresh_i,
  input wire logic wait_pin_i,
  output emu_gate_pkg::mem_ans_s ans_o,
  output logic wait_o,
  // Run control
  input wire logic break_evt_i,
  input wire logic go_cmd_i,
  input wire logic step_cmd_i,
  input wire logic sleep_enter_i,
  input wire logic wake_i,
  // Control inputs from target and host masks
  input wire logic chip_init_input_i,
  input wire logic nmi_i,
  input wire logic standby_input_i,
  input wire logic mask_wr_i,
  input wire logic [2:0] mask_wdata_i,
  // Interrupt requests
  input wire logic irq_level_i,
  input wire logic irq_edge_i,
  // Core side
  output logic run_o,
  output logic break_o,
  output logic op_mode_o,
  output logic [1:0] mode_o,
  output logic mode_valid_o,
  output logic resume_after_sleep_o,
  output logic core_init_o,
  output logic core_nmi_o,
  output logic regs_init_o,
  output logic standby_level_o,
  output logic irq_o,
  output logic trace_en_o,
  output logic break_cmp_en_o,
  output logic wdt_en_o,
  output logic periph_en_o,
  output logic xfer_en_o,
  output logic [2:0] mask_o
);
  import emu_gate_pkg::*;

  // -----------------------------------------------------------------------
  // Mode decode
  // -----------------------------------------------------------------------
  function automatic logic in_area(input area_s a, input logic [23:0] ad);
    in_area = a.en && (ad >= a.lo) && (ad <= a.hi);
  endfunction : in_area

  logic [2:0] md;
  assign md = {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i};
  logic [1:0] nxt_mode;
  logic nxt_mode_valid;
  always_comb begin
    nxt_mode = MODE_SINGLE;
    nxt_mode_valid = 1'b1;
    case (md)
      3'h4: nxt_mode = MODE_EXP16;
      3'h5: nxt_mode = MODE_EXP8;
      3'h6: nxt_mode = MODE_EXPROM;
      3'h7: nxt_mode = MODE_SINGLE;
      default: nxt_mode_valid = 1'b0;
    endcase
  end
  logic [1:0] mode_ff;
  logic mode_valid_ff;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_ff <= MODE_SINGLE;
      mode_valid_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      mode_valid_ff <= nxt_mode_valid;
    end
  end
  assign mode_o = mode_ff;
  assign mode_valid_o = mode_valid_ff;
  // Expanded modes have an external bus; single chip has none
  assign op_mode_o = (mode_ff != MODE_SINGLE);

  // -----------------------------------------------------------------------
  // Run/break state
  // -----------------------------------------------------------------------
  run_state_e state_ff;
  logic step_ff;
  logic slept_ff;
  logic init_act;
  // In break a go wins over a break in the same cycle; in run or sleep a break wins over sleep entry and wake
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || regs_init_o) begin
      state_ff <= ST_BREAK;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (break_evt_i) state_ff <= ST_BREAK;
          else if (sleep_enter_i) state_ff <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (break_evt_i) state_ff <= ST_BREAK;
          else if (wake_i) state_ff <= ST_RUN;
        end
        ST_BREAK: begin
          if (go_cmd_i || step_cmd_i) state_ff <= ST_RUN;
        end
        default: state_ff <= ST_BREAK;
      endcase
    end
  end
  // A single step enters run and sets step_ff, which masks NMI and interrupts until a go
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      step_ff <= 1'b0;
    end else if (state_ff == ST_BREAK && step_cmd_i && !go_cmd_i) begin
      step_ff <= 1'b1;
    end else if (go_cmd_i) begin
      // Any go ends a stepping session, in run as well as in break
      step_ff <= 1'b0;
    end
  end
  // Break out of sleep: resume must not re-enter sleep
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      slept_ff <= 1'b0;
    end else if (state_ff == ST_SLEEP && break_evt_i) begin
      slept_ff <= 1'b1;
    end else if (state_ff == ST_RUN) begin
      slept_ff <= 1'b0;
    end
  end
  assign resume_after_sleep_o = slept_ff && state_ff == ST_BREAK;
  assign run_o = (state_ff != ST_BREAK);
  assign break_o = (state_ff == ST_BREAK);

  // -----------------------------------------------------------------------
  // Control inputs and masks
  // -----------------------------------------------------------------------
  logic [2:0] mask_ff;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mask_ff <= {MASK_STANDBY_INPUT_RST, MASK_NMI_RST, MASK_INIT_RST};
    end else if (mask_wr_i) begin
      mask_ff <= mask_wdata_i;
    end
  end
  assign mask_o = mask_ff;
  assign init_act = chip_init_input_i && !mask_ff[0] && run_o;
  assign core_init_o = init_act;
  assign core_nmi_o = nmi_i && !mask_ff[1] && run_o && !step_ff;
  assign regs_init_o = standby_input_i && !mask_ff[2];
  assign standby_level_o = standby_input_i;

  // -----------------------------------------------------------------------
  // Interrupt gating
  // -----------------------------------------------------------------------
  logic edge_prev_ff;
  logic edge_pend_ff;
  logic irq_gate;
  assign irq_gate = (state_ff == ST_RUN) && !step_ff;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      edge_prev_ff <= 1'b0;
    end else begin
      edge_prev_ff <= irq_edge_i;
    end
  end
  // New edge wins over the clear that a service would cause
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      edge_pend_ff <= 1'b0;
    end else if (irq_edge_i && !edge_prev_ff) begin
      edge_pend_ff <= 1'b1;
    end else if (irq_gate) begin
      edge_pend_ff <= 1'b0;
    end
  end
  // Level requests are only seen while running
  assign irq_o = irq_gate && (irq_level_i || edge_pend_ff);

  // -----------------------------------------------------------------------
  // Peripheral gating
  // -----------------------------------------------------------------------
  assign wdt_en_o = (state_ff != ST_BREAK);
  assign periph_en_o = 1'b1;
  assign xfer_en_o = 1'b1;
  assign trace_en_o = (state_ff == ST_RUN) && !tte_hi_xfer_i;
  assign break_cmp_en_o = !tte_hi_xfer_i;

  // -----------------------------------------------------------------------
  // Memory steering
  // -----------------------------------------------------------------------
  mem_ans_s nxt_ans;
  logic [23:0] ad;
  logic in_tte;
  assign ad = req_i.addr;
  assign in_tte = (ad >= TTE_RAM_LO) && (ad <= TTE_RAM_HI);
  always_comb begin
    nxt_ans = '0;
    if (req_i.valid) begin
      if (in_area(rom_area_i, ad)) begin
        nxt_ans.tgt = TGT_SUB_ROM;
        nxt_ans.grant = req_i.host || !req_i.wr;
      end else if (in_area(ram_area_i, ad)) begin
        nxt_ans.tgt = TGT_SUB_RAM;
        nxt_ans.grant = !(req_i.host && run_o && in_tte);
      end else if (in_area(io_area_i, ad)) begin
        nxt_ans.tgt = TGT_IO;
        nxt_ans.grant = 1'b1;
      end else if (in_area(emu_area_i, ad)) begin
        nxt_ans.tgt = TGT_EMU_MEM;
        nxt_ans.grant = 1'b1;
      end else if (op_mode_o && in_area(ext_area_i, ad) &&
                   (ext_rw_i || ext_wprot_i)) begin
        nxt_ans.tgt = TGT_EXT;
        nxt_ans.grant = ext_rw_i || !req_i.wr;
        nxt_ans.pin_wait_ok = 1'b1;
      end else begin
        nxt_ans.tgt = TGT_NONE;
      end
      nxt_ans.blocked = !nxt_ans.grant;
    end
    if (refresh_i) begin
      nxt_ans.pin_wait_ok = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ans_o <= '0;
    end else begin
      ans_o <= nxt_ans;
    end
  end
  assign wait_o = ans_o.pin_wait_ok && wait_pin_i;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  rom_write_blk_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.wr && !req_i.host && in_area(rom_area_i, ad)
    |=> ans_o.blocked && ans_o.tgt == TGT_SUB_ROM)
    else $error("user write to substitute ROM not blocked");
  ram_steer_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i.valid && !in_area(rom_area_i, ad) && in_area(ram_area_i, ad)
    |=> ans_o.tgt == TGT_SUB_RAM)
    else $error("internal RAM access not steered");
  guard_blk_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ##1 ans_o.tgt == TGT_NONE && $past(req_i.valid) |-> ans_o.blocked)
    else $error("guarded access not blocked");
  init_break_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    break_o |-> !core_init_o)
    else $error("chip init passed in break");
  level_irq_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    break_o || step_ff |-> !irq_o)
    else $error("interrupt passed in break or step");
  edge_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    break_o && irq_edge_i && !edge_prev_ff && !regs_init_o ##1 go_cmd_i
    && !regs_init_o |=> irq_o || step_ff)
    else $error("latched edge interrupt lost");
  wdt_stop_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    run_o && break_evt_i |=> !wdt_en_o)
    else $error("watchdog still enabled after break");
  sleep_trace_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state_ff == ST_SLEEP |-> !trace_en_o)
    else $error("trace captured in sleep");
  sleep_break_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state_ff == ST_SLEEP && break_evt_i && !regs_init_o
    |=> break_o && resume_after_sleep_o)
    else $error("break from sleep not taken");
  tte_host_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i.valid && req_i.host && run_o && in_tte
    && !in_area(rom_area_i, ad) && in_area(ram_area_i, ad)
    |=> ans_o.blocked)
    else $error("host reached transfer RAM in run mode");
endmodule : emu_gate

// ### dv/target_board_model.sv
// Target board model: mode pins, control inputs, wait pin and edge request
module target_board_model (
  // Clock
  input wire logic clk_i,
  // Levels requested by the bench
  input wire logic [2:0] mode_set_i,
  input wire logic [4:0] pin_set_i,
  // Board pins: {init, nmi, standby, wait, edge irq}
  output logic [2:0] mode_pins_o,
  output logic [4:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------------
  // Pin drivers
  // -------------------------------------------------------------------
  // Board starts strapped for single chip with every input inactive
  initial begin
    mode_pins_o = 3'h7;
    pins_o = 5'h00;
  end
  // Board logic moves only just after a rising edge
  always @(posedge clk_i) begin
    mode_pins_o <= mode_set_i;
    pins_o <= pin_set_i;
  end
endmodule : target_board_model

// ### dv/testbench.sv
// Self-checking testbench of the emulator run/break gating block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import emu_gate_pkg::*;
  // -------------------------------------------------------------------
  // Signals and instances
  // -------------------------------------------------------------------
  logic sys_clk_i, sys_rst_i, ext_rw_i, ext_wprot_i, tte_hi_xfer_i;
  logic mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i;
  area_s rom_area_i, ram_area_i, io_area_i, emu_area_i, ext_area_i;
  mem_req_s req_i;
  mem_ans_s ans_o;
  logic refresh_i, wait_pin_i, wait_o, break_evt_i, go_cmd_i, step_cmd_i;
  logic sleep_enter_i, wake_i, chip_init_input_i, nmi_i, standby_input_i;
  logic mask_wr_i, irq_level_i, irq_edge_i, run_o, break_o, op_mode_o;
  logic [2:0] mask_wdata_i, mask_o, mode_set, mpins;
  logic [1:0] mode_o;
  logic [4:0] pin_set, bpins;
  logic mode_valid_o, resume_after_sleep_o, core_init_o, core_nmi_o;
  logic regs_init_o, standby_level_o, irq_o, trace_en_o, break_cmp_en_o;
  logic wdt_en_o, periph_en_o, xfer_en_o;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  // Run control pulses: {break, go, step, sleep, wake}
  localparam logic [4:0] P_BRK = 5'h10;
  localparam logic [4:0] P_GO = 5'h08;
  localparam logic [4:0] P_STEP = 5'h04;
  localparam logic [4:0] P_SLEEP = 5'h02;
  localparam logic [4:0] P_WAKE = 5'h01;

  assign {mode_select_pin_2_i, mode_select_pin_1_i, mode_select_pin_0_i} =
    mpins;
  assign {chip_init_input_i, nmi_i, standby_input_i, wait_pin_i,
    irq_edge_i} = bpins;

  target_board_model u_target_board_model (.clk_i(sys_clk_i),
    .mode_set_i(mode_set), .pin_set_i(pin_set), .mode_pins_o(mpins),
    .pins_o(bpins));

  emu_gate u_emu_gate (.sys_clk_i, .sys_rst_i, .mode_select_pin_2_i,
    .mode_select_pin_1_i, .mode_select_pin_0_i, .rom_area_i, .ram_area_i,
    .io_area_i, .emu_area_i, .ext_area_i, .ext_rw_i, .ext_wprot_i, .req_i,
    .tte_hi_xfer_i, .refresh_i, .wait_pin_i, .ans_o, .wait_o, .break_evt_i,
    .go_cmd_i, .step_cmd_i, .sleep_enter_i, .wake_i, .chip_init_input_i,
    .nmi_i, .standby_input_i, .mask_wr_i, .mask_wdata_i, .irq_level_i,
    .irq_edge_i, .run_o, .break_o, .op_mode_o, .mode_o, .mode_valid_o,
    .resume_after_sleep_o, .core_init_o, .core_nmi_o, .regs_init_o,
    .standby_level_o, .irq_o, .trace_en_o, .break_cmp_en_o, .wdt_en_o,
    .periph_en_o, .xfer_en_o, .mask_o);

  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic pulse(input logic [4:0] p);
    @(posedge sys_clk_i);
    {break_evt_i, go_cmd_i, step_cmd_i, sleep_enter_i, wake_i} <= p;
    @(posedge sys_clk_i);
    {break_evt_i, go_cmd_i, step_cmd_i, sleep_enter_i, wake_i} <= 5'h00;
    #1;
  endtask : pulse

  // Board pins need one edge in the model, one more to settle in the block
  task automatic pins(input logic [4:0] v);
    @(posedge sys_clk_i);
    pin_set <= v;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : pins

  task automatic set_mask(input logic [2:0] v);
    @(posedge sys_clk_i);
    mask_wr_i <= 1'b1;
    mask_wdata_i <= v;
    @(posedge sys_clk_i);
    mask_wr_i <= 1'b0;
    #1;
    cmp(mask_o, v);
  endtask : set_mask

  // Answer is checked one cycle after the request; wait is expected high only for external or refresh accesses
  task automatic mem(input logic wr, input logic host, input logic [23:0] a,
                     input mem_tgt_e tg, input logic g);
    @(posedge sys_clk_i);
    req_i <= '{1'b1, wr, host, a};
    @(posedge sys_clk_i);
    req_i <= '0;
    #1;
    cmp({ans_o.grant, ans_o.blocked}, {g, !g});
    if (g) begin
      cmp(ans_o.tgt, tg);
      cmp(wait_o, refresh_i | (tg == TGT_EXT));
    end
  endtask : mem

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic test_reset();
    #1;
    cmp({break_o, run_o, mode_valid_o, ans_o}, 9'h100);
    cmp(mask_o, 3'h4);
    $display("test reset done");
  endtask : test_reset

  task automatic test_mode();
    for (int c = 3; c < 8; c++) begin
      mode_set = c[2:0];
      repeat (3) @(posedge sys_clk_i);
      #1;
      cmp(mode_valid_o, c[2]);
      if (c[2]) cmp({mode_o, op_mode_o}, {c[1:0], c != 7});
    end
    @(posedge sys_clk_i);
    ext_rw_i <= 1'b1;
    mem(1'b0, 1'b0, 24'h40_0000, TGT_NONE, 1'b0);
    mode_set = 3'h4;
    repeat (3) @(posedge sys_clk_i);
    $display("test mode done");
  endtask : test_mode

  task automatic test_map();
    pins(5'h02);
    mem(1'b0, 1'b0, 24'h00_0100, TGT_SUB_ROM, 1'b1);
    mem(1'b1, 1'b0, 24'h00_0100, TGT_NONE, 1'b0);
    mem(1'b1, 1'b1, 24'h00_0100, TGT_SUB_ROM, 1'b1);
    mem(1'b1, 1'b0, 24'hff_b000, TGT_SUB_RAM, 1'b1);
    mem(1'b0, 1'b1, 24'hff_ebc0, TGT_SUB_RAM, 1'b1);
    mem(1'b1, 1'b0, 24'hff_fe10, TGT_IO, 1'b1);
    mem(1'b0, 1'b1, 24'hff_fe10, TGT_IO, 1'b1);
    mem(1'b0, 1'b0, 24'h20_0000, TGT_EMU_MEM, 1'b1);
    mem(1'b1, 1'b0, 24'h40_0000, TGT_EXT, 1'b1);
    mem(1'b0, 1'b0, 24'h80_0000, TGT_NONE, 1'b0);
    @(posedge sys_clk_i);
    ext_rw_i <= 1'b0;
    mem(1'b0, 1'b0, 24'h40_0000, TGT_NONE, 1'b0);
    @(posedge sys_clk_i);
    ext_wprot_i <= 1'b1;
    mem(1'b0, 1'b0, 24'h40_0000, TGT_EXT, 1'b1);
    mem(1'b1, 1'b0, 24'h40_0000, TGT_NONE, 1'b0);
    @(posedge sys_clk_i);
    refresh_i <= 1'b1;
    mem(1'b0, 1'b0, 24'h20_0000, TGT_EMU_MEM, 1'b1);
    @(posedge sys_clk_i);
    refresh_i <= 1'b0;
    $display("test map done");
  endtask : test_map

  task automatic test_run();
    pins(5'h10);
    cmp({core_init_o, wdt_en_o, periph_en_o, xfer_en_o}, 4'h3);
    pulse(P_GO);
    cmp({run_o, break_o, wdt_en_o, core_init_o, trace_en_o}, 5'h17);
    mem(1'b0, 1'b1, 24'hff_ebc0, TGT_NONE, 1'b0);
    mem(1'b0, 1'b0, 24'hff_ebc0, TGT_SUB_RAM, 1'b1);
    @(posedge sys_clk_i);
    tte_hi_xfer_i <= 1'b1;
    #1;
    cmp({trace_en_o, break_cmp_en_o}, 2'h0);
    @(posedge sys_clk_i);
    tte_hi_xfer_i <= 1'b0;
    set_mask(3'h1);
    cmp(core_init_o, 1'b0);
    pins(5'h08);
    cmp(core_nmi_o, 1'b1);
    set_mask(3'h3);
    cmp(core_nmi_o, 1'b0);
    pulse(P_SLEEP);
    cmp({run_o, trace_en_o, wdt_en_o}, 3'h5);
    pulse(P_WAKE);
    cmp({run_o, trace_en_o}, 2'h3);
    pulse(P_SLEEP);
    pulse(P_BRK);
    cmp({break_o, resume_after_sleep_o, wdt_en_o}, 3'h6);
    cmp({periph_en_o, xfer_en_o}, 2'h3);
    $display("test run done");
  endtask : test_run

  task automatic test_irq();
    @(posedge sys_clk_i);
    irq_level_i <= 1'b1;
    #1;
    cmp(irq_o, 1'b0);
    @(posedge sys_clk_i);
    irq_level_i <= 1'b0;
    pins(5'h01);
    pins(5'h00);
    pulse(P_GO);
    cmp(irq_o, 1'b1);
    pulse(P_BRK);
    pulse(P_STEP);
    @(posedge sys_clk_i);
    irq_level_i <= 1'b1;
    #1;
    cmp({run_o, irq_o}, 2'h2);
    pulse(P_BRK);
    pulse(P_GO);
    cmp(irq_o, 1'b1);
    @(posedge sys_clk_i);
    irq_level_i <= 1'b0;
    pulse(P_BRK);
    // Edge reaches the block two edges on; go follows it at once
    @(posedge sys_clk_i);
    pin_set <= 5'h01;
    repeat (2) @(posedge sys_clk_i);
    go_cmd_i <= 1'b1;
    @(posedge sys_clk_i);
    go_cmd_i <= 1'b0;
    pin_set <= 5'h00;
    #1;
    cmp(irq_o, 1'b1);
    $display("test irq done");
  endtask : test_irq

  task automatic test_standby_input();
    set_mask(3'h4);
    pins(5'h04);
    cmp({standby_level_o, regs_init_o, break_o}, 3'h4);
    set_mask(3'h0);
    cmp(regs_init_o, 1'b1);
    @(posedge sys_clk_i);
    #1;
    cmp(break_o, 1'b1);
    $display("test standby done");
  endtask : test_standby_input

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Whole run takes about 120 cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    {tte_hi_xfer_i, refresh_i, break_evt_i, go_cmd_i, step_cmd_i} = 5'h00;
    {sleep_enter_i, wake_i, mask_wr_i, irq_level_i, ext_rw_i} = 5'h00;
    ext_wprot_i = 1'b0;
    mask_wdata_i = 3'h0;
    req_i = '0;
    mode_set = 3'h7;
    pin_set = 5'h00;
    rom_area_i = '{1'b1, 24'h00_0000, 24'h03_ffff};
    ram_area_i = '{1'b1, 24'hff_b000, 24'hff_efbf};
    io_area_i = '{1'b1, 24'hff_fe00, 24'hff_ffff};
    emu_area_i = '{1'b1, 24'h20_0000, 24'h3f_ffff};
    ext_area_i = '{1'b1, 24'h40_0000, 24'h7f_ffff};
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    test_reset();
    test_mode();
    test_map();
    test_run();
    test_irq();
    test_standby_input();
    give_verdict();
  end
endmodule : testbench
